/* common/gspi_pkg.sv */
// Shared constants, types and helpers for the serial host controller
package gspi_pkg;
  // ==========================================================================
  // Frame and FIFO geometry
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 64;
  localparam logic [5:0] MIN_LEN = 6'h04;
  localparam logic [5:0] MAX_LEN = 6'h20;
  localparam int OUT_BUF_DEPTH = 2;
  // ==========================================================================
  // Serial timing: fastest bit rate sets the shortest half period
  localparam int REF_CLK_KHZ = 100000;
  localparam int MAX_RATE_KBPS = 20000;
  localparam int MIN_HALF_INT = (REF_CLK_KHZ + 2 * MAX_RATE_KBPS - 1) / (2 * MAX_RATE_KBPS);
  localparam logic [7:0] MIN_HALF = 8'(MIN_HALF_INT);
  // ==========================================================================
  // Idle pin levels, latency report, transfer widths
  localparam logic SCLK_IDLE = 1'b0;
  localparam logic CS_IDLE = 1'b1;
  localparam logic MOSI_IDLE = 1'b0;
  localparam int LTR_W = 10;
  localparam logic [LTR_W-1:0] LTR_NONE = 10'h000;
  localparam logic [1:0] SIZE_1B = 2'h0;
  localparam logic [1:0] SIZE_2B = 2'h1;
  localparam logic [1:0] SIZE_4B = 2'h2;
  localparam int BLK_W = 16;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_t;
  typedef struct packed {
    logic dma_done;
    logic rx_overrun;
    logic tx_thresh;
    logic rx_thresh;
    logic tx_done;
  } status_t;
  localparam spi_pins_t PINS_IDLE = '{sclk: SCLK_IDLE, cs_n: CS_IDLE, mosi: MOSI_IDLE};
  // ==========================================================================
  // Helpers
  function automatic logic [DATA_W-1:0] len_mask(input logic [5:0] len);
    len_mask = (len >= MAX_LEN) ? {DATA_W{1'b1}} : ((32'h1 << len) - 32'h1);
  endfunction
  function automatic logic [DATA_W-1:0] size_mask(input logic [1:0] sel);
    size_mask = (sel == SIZE_1B) ? 32'h000000FF : (sel == SIZE_2B) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction
  function automatic logic [BLK_W-1:0] size_bytes(input logic [1:0] sel);
    size_bytes = (sel == SIZE_1B) ? 16'h0001 : (sel == SIZE_2B) ? 16'h0002 : 16'h0004;
  endfunction
endpackage

/* hw/gspi_host.sv */
// Serial host controller: FIFOs, shift engine, DMA handshake, status
`timescale 1ns/1ns

// ============================================================================
// Synchronous FIFO with registered flags
module gspi_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] next_level;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;
  assign next_level = level_o + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level_o <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      level_o <= next_level;
      in_ready_o <= (next_level != FULL_CNT);
      out_valid_o <= (next_level != '0);
    end
  end

  // Storage needs no reset, only pointers, level and flags do
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // gspi_fifo

// ============================================================================
// How it works
// - Host only, drives clock and select
// - Frames 4 to 32 bits, 64-entry FIFOs
// - Bit rate capped at 20 Mbit/s
// - Transmit bits above frame length dropped
// - Receive words right-justified, upper bits zero
// - Serialise transmit words, assemble receive words
// - Threshold crossings raise interrupt or DMA request
// - DMA both directions, peripheral controls flow
// - DMA block loaded by direct programming
// - Memory and peripheral widths set independently
// - Bursts power of two, 1 to 64; a 128 setting never requests
// - Block size in bytes, partial tail
// - Address incrementing or constant per block
// - Any handshake to any channel, abortable
// - Held in reset until software releases
// - Power gate freezes bus pins
// - Latency report hardware or driver chosen
// - Sticky status, cleared by write, set wins
// - Receive overrun captured as error status
module gspi_host #(
  parameter int CH = 4,
  parameter logic [gspi_pkg::LTR_W-1:0] LTR_ACTIVE = 10'h010
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ctrl_release_i,
  // Configuration
  input wire logic [5:0] frame_len_i,
  input wire logic [7:0] half_period_i,
  input wire logic [6:0] tx_thresh_i,
  input wire logic [6:0] rx_thresh_i,
  input wire logic power_gate_i,
  // Transmit words from processor or DMA
  input wire logic tx_valid_i,
  input wire logic [gspi_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_from_dma_i,
  output logic tx_ready_o,
  // Receive words
  output logic rx_valid_o,
  output logic [gspi_pkg::DATA_W-1:0] rx_data_o,
  input wire logic rx_ready_i,
  // DMA handshake
  input wire logic [CH-1:0] dma_chan_en_i,
  input wire logic [$clog2(CH)-1:0] dma_tx_chan_i,
  input wire logic [$clog2(CH)-1:0] dma_rx_chan_i,
  input wire logic dma_tx_en_i,
  input wire logic dma_rx_en_i,
  input wire logic [2:0] burst_log2_i,
  input wire logic [1:0] extended_size_select_i,
  input wire logic dma_abort_i,
  output logic [CH-1:0] dma_tx_req_o,
  output logic [CH-1:0] dma_rx_req_o,
  // DMA block address engine
  input wire logic blk_start_i,
  input wire logic [31:0] blk_addr_i,
  input wire logic [gspi_pkg::BLK_W-1:0] blk_bytes_i,
  input wire logic [1:0] mem_size_i,
  input wire logic addr_incr_i,
  input wire logic mem_beat_i,
  output logic [31:0] dma_addr_o,
  output logic blk_busy_o,
  // Status and interrupt
  input wire gspi_pkg::status_t status_clr_i,
  input wire gspi_pkg::status_t irq_en_i,
  output gspi_pkg::status_t status_o,
  output logic irq_o,
  // Latency report
  input wire logic ltr_sel_i,
  input wire logic [gspi_pkg::LTR_W-1:0] ltr_drv_i,
  output logic [gspi_pkg::LTR_W-1:0] ltr_o,
  // Serial pins
  output gspi_pkg::spi_pins_t spi_o,
  input wire logic miso_i
);
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_NEXT} state_t;
  localparam int LW = $clog2(gspi_pkg::FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] DEPTH_L = LW'(gspi_pkg::FIFO_DEPTH);
  localparam int DW = gspi_pkg::DATA_W;

  state_t state;
  logic blk_rst;
  logic miso_m;
  logic miso_s;
  logic [7:0] half_cnt;
  logic [7:0] half_lim;
  logic [5:0] bit_cnt;
  logic [5:0] cur_len;
  logic [5:0] len_eff;
  logic [DW-1:0] tx_sr;
  logic [DW-1:0] rx_sr;
  logic [DW-1:0] tx_word;
  logic [DW-1:0] load_word;
  logic tx_out_valid;
  logic [DW-1:0] tx_out_data;
  logic [LW-1:0] tx_lvl;
  logic [LW-1:0] rx_lvl;
  logic tx_pop;
  logic rx_push;
  logic rx_in_ready;
  logic mid_valid;
  logic mid_ready;
  logic [DW-1:0] mid_data;
  logic [7:0] burst;
  logic tx_thr_cond;
  logic rx_thr_cond;
  logic tx_thr_q;
  logic rx_thr_q;
  logic [gspi_pkg::BLK_W-1:0] blk_rem;
  logic [gspi_pkg::BLK_W-1:0] mem_bytes;
  gspi_pkg::status_t ev;
  gspi_pkg::status_t next_status;

  // ==========================================================================
  // Reset and input synchronisers
  assign blk_rst = sys_rst_i | ~ctrl_release_i;

  always_ff @(posedge ref_clk_i)
  begin
    miso_m <= miso_i;
    miso_s <= miso_m;
  end

  // ==========================================================================
  // FIFOs and output buffer
  assign len_eff = (frame_len_i < gspi_pkg::MIN_LEN) ? gspi_pkg::MIN_LEN :
                   (frame_len_i > gspi_pkg::MAX_LEN) ? gspi_pkg::MAX_LEN : frame_len_i;
  // DMA writes also lose bytes beyond their transfer size
  assign tx_word = tx_data_i & gspi_pkg::len_mask(len_eff) &
                   (tx_from_dma_i ? gspi_pkg::size_mask(extended_size_select_i) : '1);

  gspi_fifo #(.W(DW), .DEPTH(gspi_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk_i(ref_clk_i), .rst_i(blk_rst),
    .in_valid_i(tx_valid_i), .in_ready_o(tx_ready_o), .in_data_i(tx_word),
    .out_valid_o(tx_out_valid), .out_ready_i(tx_pop), .out_data_o(tx_out_data),
    .level_o(tx_lvl)
  );
  gspi_fifo #(.W(DW), .DEPTH(gspi_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk_i(ref_clk_i), .rst_i(blk_rst),
    .in_valid_i(rx_push), .in_ready_o(rx_in_ready), .in_data_i(rx_sr),
    .out_valid_o(mid_valid), .out_ready_i(mid_ready), .out_data_o(mid_data),
    .level_o(rx_lvl)
  );
  // Reader stall backs up into the receive FIFO, then shows as overrun
  gspi_fifo #(.W(DW), .DEPTH(gspi_pkg::OUT_BUF_DEPTH)) u_out_buf (
    .clk_i(ref_clk_i), .rst_i(blk_rst),
    .in_valid_i(mid_valid), .in_ready_o(mid_ready), .in_data_i(mid_data),
    .out_valid_o(rx_valid_o), .out_ready_i(rx_ready_i), .out_data_o(rx_data_o),
    .level_o()
  );

  // ==========================================================================
  // Shift engine, mode 0: launch on falling edge, sample before it
  assign half_lim = (half_period_i < gspi_pkg::MIN_HALF) ? gspi_pkg::MIN_HALF
                    : half_period_i;
  assign load_word = tx_out_data << (gspi_pkg::MAX_LEN - len_eff);
  assign tx_pop = (state != S_SHIFT) & tx_out_valid & ~power_gate_i;
  assign rx_push = (state == S_NEXT) & ~power_gate_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (blk_rst)
    begin
      state <= S_IDLE;
      spi_o <= gspi_pkg::PINS_IDLE;
      half_cnt <= '0;
      bit_cnt <= '0;
      cur_len <= gspi_pkg::MIN_LEN;
      tx_sr <= '0;
      rx_sr <= '0;
    end
    else if (!power_gate_i)
    begin
      if (tx_pop)
      begin
        cur_len <= len_eff;
        tx_sr <= load_word;
        spi_o.mosi <= load_word[DW-1];
        spi_o.cs_n <= 1'b0;
        half_cnt <= '0;
        bit_cnt <= '0;
        rx_sr <= '0;
        state <= S_SHIFT;
      end
      else
      begin
        unique case (state)
          S_IDLE:
          begin
            spi_o <= gspi_pkg::PINS_IDLE;
          end
          S_SHIFT:
          begin
            if (half_cnt == half_lim - 8'h01)
            begin
              half_cnt <= '0;
              spi_o.sclk <= ~spi_o.sclk;
              if (spi_o.sclk)
              begin
                rx_sr <= {rx_sr[DW-2:0], miso_s};
                if (bit_cnt == cur_len - 6'h01)
                begin
                  state <= S_NEXT;
                end
                else
                begin
                  bit_cnt <= bit_cnt + 6'h01;
                  tx_sr <= tx_sr << 1;
                  spi_o.mosi <= tx_sr[DW-2];
                end
              end
            end
            else
            begin
              half_cnt <= half_cnt + 8'h01;
            end
          end
          S_NEXT:
          begin
            spi_o <= gspi_pkg::PINS_IDLE;
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Thresholds and DMA requests
  assign burst = 8'h01 << burst_log2_i;
  assign tx_thr_cond = (tx_lvl <= LW'(tx_thresh_i));
  assign rx_thr_cond = (rx_lvl > LW'(rx_thresh_i));

  always_ff @(posedge ref_clk_i)
  begin
    if (blk_rst)
    begin
      dma_tx_req_o <= '0;
      dma_rx_req_o <= '0;
    end
    else
    begin
      // Peripheral paces both directions by its FIFO levels
      dma_tx_req_o <= '0;
      dma_rx_req_o <= '0;
      dma_tx_req_o[dma_tx_chan_i] <= dma_tx_en_i & tx_thr_cond & blk_busy_o & ~dma_abort_i &
        dma_chan_en_i[dma_tx_chan_i] & ({1'b0, DEPTH_L - tx_lvl} >= {1'b0, burst});
      dma_rx_req_o[dma_rx_chan_i] <= dma_rx_en_i & rx_thr_cond & blk_busy_o & ~dma_abort_i &
        dma_chan_en_i[dma_rx_chan_i] & ({1'b0, rx_lvl} >= {1'b0, burst});
    end
  end

  // ==========================================================================
  // Block address engine, memory width apart from peripheral width
  assign mem_bytes = gspi_pkg::size_bytes(mem_size_i);

  always_ff @(posedge ref_clk_i)
  begin
    if (blk_rst)
    begin
      dma_addr_o <= '0;
      blk_rem <= '0;
      blk_busy_o <= 1'b0;
    end
    else if (dma_abort_i)
    begin
      blk_rem <= '0;
      blk_busy_o <= 1'b0;
    end
    else if (blk_start_i)
    begin
      dma_addr_o <= blk_addr_i;
      blk_rem <= blk_bytes_i;
      blk_busy_o <= (blk_bytes_i != '0);
    end
    else if (blk_busy_o && mem_beat_i)
    begin
      dma_addr_o <= addr_incr_i ? dma_addr_o + {16'h0000, mem_bytes} : dma_addr_o;
      blk_rem <= (blk_rem <= mem_bytes) ? '0 : blk_rem - mem_bytes;
      blk_busy_o <= (blk_rem > mem_bytes);
    end
  end

  // ==========================================================================
  // Sticky status, latency report
  always_comb
  begin
    ev.tx_done = (state == S_NEXT) & ~tx_out_valid & ~power_gate_i;
    ev.rx_thresh = rx_thr_cond & ~rx_thr_q;
    ev.tx_thresh = tx_thr_cond & ~tx_thr_q;
    ev.rx_overrun = rx_push & ~rx_in_ready;
    ev.dma_done = blk_busy_o & mem_beat_i & ~dma_abort_i & ~blk_start_i & (blk_rem <= mem_bytes);
    next_status = gspi_pkg::status_t'((status_o & ~status_clr_i) | ev);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (blk_rst)
    begin
      status_o <= '0;
      irq_o <= 1'b0;
      tx_thr_q <= 1'b0;
      rx_thr_q <= 1'b0;
    end
    else
    begin
      status_o <= next_status;
      irq_o <= |(next_status & irq_en_i);
      tx_thr_q <= tx_thr_cond;
      rx_thr_q <= rx_thr_cond;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (blk_rst)
    begin
      ltr_o <= gspi_pkg::LTR_NONE;
    end
    else
    begin
      ltr_o <= ltr_sel_i ? ltr_drv_i : ((state != S_IDLE) ? LTR_ACTIVE : gspi_pkg::LTR_NONE);
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (blk_rst);

  property p_cs_frame;
    spi_o.sclk |-> !spi_o.cs_n;
  endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("clock high without select");
  property p_half_min;
    $rose(spi_o.sclk) |-> spi_o.sclk [*3];
  endproperty
  a_half_min: assert property (p_half_min) else $error("clock high phase too short");
  property p_pg_quiet;
    (power_gate_i ##1 1'b1) |-> $stable(spi_o);
  endproperty
  a_pg_quiet: assert property (p_pg_quiet) else $error("pins moved in power gate");
  property p_tx_trim;
    tx_valid_i && tx_ready_o |-> ((tx_word & ~gspi_pkg::len_mask(len_eff)) == '0);
  endproperty
  a_tx_trim: assert property (p_tx_trim) else $error("transmit word not trimmed");
  property p_rx_just;
    rx_push |-> ((rx_sr & ~gspi_pkg::len_mask(cur_len)) == '0);
  endproperty
  a_rx_just: assert property (p_rx_just) else $error("receive word not justified");
  property p_set_wins;
    ev.tx_done && status_clr_i.tx_done |=> status_o.tx_done;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
  property p_ltr_idle;
    !ltr_sel_i && state == S_IDLE |=> ltr_o == gspi_pkg::LTR_NONE;
  endproperty
  a_ltr_idle: assert property (p_ltr_idle) else $error("idle latency not none");
  property p_release;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !ctrl_release_i |=> spi_o.cs_n && !spi_o.sclk && !irq_o;
  endproperty
  a_release: assert property (p_release) else $error("active while held in reset");
  property p_abort;
    dma_abort_i |=> (dma_tx_req_o == '0) ##1 (dma_tx_req_o == '0) && !blk_busy_o;
  endproperty
  a_abort: assert property (p_abort) else $error("request after abort");
  property p_overrun;
    rx_push && !rx_in_ready |=> status_o.rx_overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  c_frame: cover property (rx_push);
  c_back2back: cover property (state == S_NEXT && tx_out_valid && !power_gate_i);
  c_overrun: cover property (ev.rx_overrun);
  c_dma_done: cover property (ev.dma_done);
endmodule // gspi_host

/* sim/spi_peer.sv */
// Serial peripheral model that answers every frame of the host
`timescale 1ns/1ns

// ============================================================================
// Peripheral model
module spi_peer #(
  parameter logic [31:0] REPLY = 32'hC3A5_96E1
) (
  // Host pins
  input wire gspi_pkg::spi_pins_t spi_i,
  input wire logic [5:0] len_i,
  // Reply line
  output logic miso_o,
  // Observed traffic
  output logic [31:0] last_word_o,
  output int frames_o,
  output int selects_o
);
  int fall_cnt = 0;
  int rise_cnt = 0;
  logic [31:0] shift = 32'h0000_0000;
  initial
  begin
    last_word_o = 32'h0000_0000;
    frames_o = 0;
    selects_o = 0;
  end
  // Deselected line falls to its pull-down, never the last bit
  assign miso_o = spi_i.cs_n ? 1'b0 : REPLY[int'(len_i) - 1 - fall_cnt];
  always @(negedge spi_i.cs_n)
    selects_o <= selects_o + 1;
  // Reply bit moves on the falling clock, stable through the high half
  always @(negedge spi_i.sclk or posedge spi_i.cs_n)
  begin
    if (spi_i.cs_n)
      fall_cnt <= 0;
    else
      fall_cnt <= (fall_cnt + 1 == int'(len_i)) ? 0 : fall_cnt + 1;
  end
  // Clock toggling while deselected is ignored
  always @(posedge spi_i.sclk or posedge spi_i.cs_n)
  begin
    if (spi_i.cs_n)
    begin
      rise_cnt <= 0;
      shift = 32'h0000_0000;
    end
    else if (rise_cnt + 1 == int'(len_i))
    begin
      last_word_o <= {shift[30:0], spi_i.mosi};
      frames_o <= frames_o + 1;
      rise_cnt <= 0;
      shift = 32'h0000_0000;
    end
    else
    begin
      shift = {shift[30:0], spi_i.mosi};
      rise_cnt <= rise_cnt + 1;
    end
  end
endmodule // spi_peer

/* sim/testbench.sv */
// Self-checking bench for the serial host controller
`timescale 1ns/1ns

module testbench;
  // ==========================================================================
  // Stimulus and observation
  localparam logic [31:0] REPLY = 32'hC3A5_96E1;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ctrl_release_i = 1'b0;
  logic [5:0] frame_len_i = 6'h08;
  logic [7:0] half_period_i = 8'h08;
  logic [6:0] tx_thresh_i = 7'h08;
  logic [6:0] rx_thresh_i = 7'h3F;
  logic power_gate_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [31:0] tx_data_i = 32'h0000_0000;
  logic tx_from_dma_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic [3:0] dma_chan_en_i = 4'h0;
  logic [1:0] dma_tx_chan_i = 2'h2;
  logic [1:0] dma_rx_chan_i = 2'h1;
  logic dma_tx_en_i = 1'b0;
  logic dma_rx_en_i = 1'b0;
  logic [2:0] burst_log2_i = 3'h0;
  logic [1:0] extended_size_select_i = 2'h2;
  logic dma_abort_i = 1'b0;
  logic blk_start_i = 1'b0;
  logic [31:0] blk_addr_i = 32'h0000_0000;
  logic [15:0] blk_bytes_i = 16'h0000;
  logic [1:0] mem_size_i = 2'h2;
  logic addr_incr_i = 1'b1;
  logic mem_beat_i = 1'b0;
  gspi_pkg::status_t status_clr_i = 5'h00;
  gspi_pkg::status_t irq_en_i = 5'h00;
  logic ltr_sel_i = 1'b0;
  logic [9:0] ltr_drv_i = 10'h000;
  logic tx_ready_o, rx_valid_o, irq_o, blk_busy_o, miso;
  logic [31:0] rx_data_o, dma_addr_o, peer_word;
  logic [3:0] dma_tx_req_o, dma_rx_req_o;
  gspi_pkg::status_t status_o;
  logic [9:0] ltr_o;
  gspi_pkg::spi_pins_t spi_o, snap;
  int peer_frames, peer_selects, err_total = 0, num_checks = 0;

  gspi_host i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ctrl_release_i(ctrl_release_i),
    .frame_len_i(frame_len_i), .half_period_i(half_period_i), .tx_thresh_i(tx_thresh_i),
    .rx_thresh_i(rx_thresh_i), .power_gate_i(power_gate_i), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_from_dma_i(tx_from_dma_i), .tx_ready_o(tx_ready_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
    .dma_chan_en_i(dma_chan_en_i), .dma_tx_chan_i(dma_tx_chan_i), .dma_rx_chan_i(dma_rx_chan_i),
    .dma_tx_en_i(dma_tx_en_i), .dma_rx_en_i(dma_rx_en_i), .burst_log2_i(burst_log2_i),
    .extended_size_select_i(extended_size_select_i), .dma_abort_i(dma_abort_i),
    .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o), .blk_start_i(blk_start_i),
    .blk_addr_i(blk_addr_i), .blk_bytes_i(blk_bytes_i), .mem_size_i(mem_size_i),
    .addr_incr_i(addr_incr_i), .mem_beat_i(mem_beat_i), .dma_addr_o(dma_addr_o),
    .blk_busy_o(blk_busy_o), .status_clr_i(status_clr_i), .irq_en_i(irq_en_i),
    .status_o(status_o), .irq_o(irq_o), .ltr_sel_i(ltr_sel_i), .ltr_drv_i(ltr_drv_i),
    .ltr_o(ltr_o), .spi_o(spi_o), .miso_i(miso));
  spi_peer #(.REPLY(REPLY)) i_peer (.spi_i(spi_o), .len_i(frame_len_i), .miso_o(miso),
    .last_word_o(peer_word), .frames_o(peer_frames), .selects_o(peer_selects));

  always #5 ref_clk_i = ~ref_clk_i;

  // ==========================================================================
  // Shared tasks
  function automatic logic [31:0] lmask(input logic [5:0] len);
    lmask = (len >= 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len) - 32'h0000_0001);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    case (k)
      0: blk_start_i <= 1'b1;
      1: mem_beat_i <= 1'b1;
      default: dma_abort_i <= 1'b1;
    endcase
    @(posedge ref_clk_i);
    blk_start_i <= 1'b0;
    mem_beat_i <= 1'b0;
    dma_abort_i <= 1'b0;
    tick(2);
  endtask
  task automatic push(input logic [31:0] word);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= word;
    @(posedge ref_clk_i);
    while (tx_ready_o !== 1'b1 && n < 9000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    tx_valid_i <= 1'b0;
  endtask
  task automatic pop(input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    rx_ready_i <= 1'b1;
    @(posedge ref_clk_i);
    while (rx_valid_o !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    check("rx valid", 32'h1, rx_valid_o);
    check("rx word", exp, rx_data_o);
    rx_ready_i <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (status_o.tx_done !== 1'b1 && n < 5000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    check("tx done", 32'h1, status_o.tx_done);
    @(posedge ref_clk_i);
    status_clr_i <= 5'h1F;
    @(posedge ref_clk_i);
    status_clr_i <= 5'h00;
    tick(2);
    check("status cleared", 32'h0, status_o);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_hold();
    tick(20);
    sys_rst_i <= 1'b0;
    tx_valid_i <= 1'b1;
    tick(50);
    check("held pins", gspi_pkg::PINS_IDLE, spi_o);
    check("held selects", 32'h0, peer_selects);
    check("held ready", 32'h1, tx_ready_o);
    tx_valid_i <= 1'b0;
    ctrl_release_i <= 1'b1;
    tick(100);
    check("released pins", gspi_pkg::PINS_IDLE, spi_o);
  endtask
  task automatic t_frame(input logic [5:0] len, input logic [31:0] word, input logic [31:0] sent);
    frame_len_i <= len;
    push(word);
    wait_done();
    check("peer word", sent, peer_word);
    pop(REPLY & lmask(len));
  endtask
  task automatic t_gate();
    int n;
    n = 0;
    frame_len_i <= 6'h10;
    push(32'h0000_9C35);
    while (spi_o.cs_n !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    tick(40);
    power_gate_i <= 1'b1;
    tick(3);
    snap = spi_o;
    check("active latency", 32'h010, ltr_o);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk_i);
      check("frozen pins", snap, spi_o);
    end
    power_gate_i <= 1'b0;
    wait_done();
    check("gated word", 32'h0000_9C35, peer_word);
    pop(REPLY & 32'h0000_FFFF);
    check("idle latency", 32'h000, ltr_o);
    ltr_sel_i <= 1'b1;
    ltr_drv_i <= 10'h2A5;
    tick(3);
    check("driver latency", 32'h2A5, ltr_o);
    ltr_sel_i <= 1'b0;
  endtask
  task automatic t_fill();
    int n;
    n = peer_selects;
    frame_len_i <= 6'h04;
    power_gate_i <= 1'b1;
    for (int i = 0; i < 64; i++)
      push(32'(i));
    tick(2);
    check("fifo full", 32'h0, tx_ready_o);
    power_gate_i <= 1'b0;
    wait_done();
    tick(20);
    check("one select", n + 1, peer_selects);
    check("last word", 32'hF, peer_word);
    // Two more words fill the receive side, the third is lost
    for (int i = 0; i < 3; i++)
      push(32'h0000_0005);
    tick(250);
    check("rx overrun", 32'h1, status_o.rx_overrun);
    dma_chan_en_i <= 4'h6;
    dma_rx_en_i <= 1'b1;
    rx_thresh_i <= 7'h10;
    burst_log2_i <= 3'h3;
    blk_bytes_i <= 16'h0100;
    pulse(0);
    tick(2);
    check("rx request", 32'h2, dma_rx_req_o);
    pulse(2);
    check("aborted rx", 32'h0, dma_rx_req_o);
    dma_rx_en_i <= 1'b0;
    burst_log2_i <= 3'h0;
    for (int i = 0; i < 66; i++)
      pop(REPLY & 32'hF);
    tick(4);
    check("rx empty", 32'h0, rx_valid_o);
  endtask
  task automatic t_dma();
    status_clr_i <= 5'h1F;
    tick(1);
    status_clr_i <= 5'h00;
    irq_en_i <= 5'h10;
    dma_tx_en_i <= 1'b1;
    blk_addr_i <= 32'h0000_1000;
    blk_bytes_i <= 16'h0006;
    addr_incr_i <= 1'b1;
    pulse(0);
    check("tx request", 32'h4, dma_tx_req_o);
    pulse(1);
    check("incr addr", 32'h0000_1004, dma_addr_o);
    check("busy", 32'h1, blk_busy_o);
    pulse(1);
    check("tail done", 32'h10, status_o);
    check("irq", 32'h1, irq_o);
    check("req off", 32'h0, dma_tx_req_o);
    blk_addr_i <= 32'h0000_2000;
    blk_bytes_i <= 16'h0008;
    addr_incr_i <= 1'b0;
    status_clr_i <= 5'h10;
    pulse(0);
    status_clr_i <= 5'h00;
    pulse(1);
    check("const addr", 32'h0000_2000, dma_addr_o);
    pulse(2);
    check("aborted busy", 32'h0, blk_busy_o);
    check("aborted req", 32'h0, dma_tx_req_o);
    dma_tx_en_i <= 1'b0;
    tx_from_dma_i <= 1'b1;
    extended_size_select_i <= gspi_pkg::SIZE_1B;
    t_frame(6'h10, 32'h1234_ABCD, 32'h0000_00CD);
    tx_from_dma_i <= 1'b0;
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic print_verdict();
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    t_hold();
    t_frame(6'h04, 32'hFFFF_FFF6, 32'h0000_0006);
    t_frame(6'h08, 32'hFFFF_A5C3, 32'h0000_00C3);
    t_frame(6'h20, 32'h8000_0001, 32'h8000_0001);
    t_gate();
    t_fill();
    t_dma();
    print_verdict();
  end
  // Run needs about 6300 cycles; allow six times that
  initial
  begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule // testbench
